// *** hw/dchannel_link_pkg.sv ***
package dchannel_link_pkg;

  // Indirect register addresses
  localparam logic [7:0] ADDR_LINK_MODE_ONE       = 8'h86;
  localparam logic [7:0] ADDR_ERROR_IRQ_ENABLE    = 8'h87;
  localparam logic [7:0] ADDR_RANDOM_VALUE_LOW    = 8'h8A;
  localparam logic [7:0] ADDR_RANDOM_VALUE_HIGH   = 8'h8B;
  localparam logic [7:0] ADDR_STATUS_IRQ_ENABLE   = 8'h8E;
  localparam logic [7:0] ADDR_THRESHOLD_FRAMING   = 8'h8F;
  localparam logic [7:0] ADDR_ADDRESS_MATCH_STAT  = 8'h91;
  localparam logic [7:0] ADDR_TRANSMIT_FIFO_PORT  = 8'h92;
  localparam logic [7:0] ADDR_RECEIVE_FIFO_PORT   = 8'h93;

  // Reset values and random generator taps
  localparam logic [7:0] RST_LINK_MODE_ONE        = 8'h00;
  localparam logic [7:0] RST_ERROR_IRQ_ENABLE     = 8'h00;
  localparam logic [7:0] RST_STATUS_IRQ_ENABLE    = 8'h03;
  localparam logic [7:0] RST_THRESHOLD_FRAMING    = 8'h00;
  localparam logic [15:0] RST_RANDOM_SEED         = 16'hACE1;
  localparam logic [15:0] RANDOM_TAPS             = 16'hB400;

  // link_mode_one fields
  localparam int LM1_TX_THRESH_IRQ = 0;
  localparam int LM1_RX_THRESH_IRQ = 1;
  localparam int LM1_TX_ADDR_EN    = 2;
  localparam int LM1_END_RX_IRQ    = 3;
  localparam int LM1_PAIR_EN_LSB   = 4;

  // status_irq_enable fields
  localparam int SIE_VALID_ADDR    = 0;
  localparam int SIE_END_TX_PKT    = 1;
  localparam int SIE_LAST_RX_BYTE  = 2;
  localparam int SIE_RX_BYTE_AVAIL = 3;
  localparam int SIE_LAST_BYTE_TX  = 4;
  localparam int SIE_TX_BUF_AVAIL  = 5;
  localparam int SIE_RX_PKT_LOST   = 6;
  localparam int SIE_FCS_TO_FIFO   = 7;

  // threshold_and_framing_mode fields
  localparam int TFM_RX_THRESH_LSB = 0;
  localparam int TFM_TX_THRESH_LSB = 2;
  localparam int TFM_FLAG_IDLE     = 4;
  localparam int TFM_SINGLE_BYTE   = 5;
  localparam int TFM_CR_COMPARE    = 6;
  localparam int TFM_SECOND_ONLY   = 7;
  localparam int CR_BIT            = 1;

  // Threshold tables in bytes, indexed by code
  localparam logic [4:0] RX_THRESH_NORMAL [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
  localparam logic [4:0] RX_THRESH_EXT    [4] = '{5'h01, 5'h10, 5'h18, 5'h1E};
  localparam logic [4:0] TX_THRESH_NORMAL [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
  localparam logic [4:0] TX_THRESH_EXT    [4] = '{5'h01, 5'h06, 5'h0A, 5'h0E};

  localparam int PAIR_COUNT   = 4;
  localparam int MATCH_DEPTH  = 2;
  localparam int FIFO_DEPTH   = 4;

  typedef struct packed {
    logic [7:0] first_byte;
    logic [7:0] second_byte;
  } addr_pair_type;

  typedef struct packed {
    logic       tx_threshold;
    logic       rx_threshold;
    logic       valid_address;
    logic       end_rx_packet;
    logic       end_tx_packet;
    logic       last_rx_byte;
    logic       rx_byte_avail;
    logic       last_byte_tx;
    logic       tx_buf_avail;
    logic       rx_packet_lost;
    logic [7:0] link_error_flags;
  } irq_sources_type;

endpackage

// *** hw/dchannel_link_mode_registers.sv ***
// Operation
// - link_mode_one bit 0 gates transmit-threshold interrupt; default off.
// - link_mode_one bit 1 gates receive-threshold interrupt; default off.
// - link_mode_one bit 2 selects transmit address value for outgoing packets.
// - link_mode_one bit 3 enables end-of-receive-packet interrupt; default off.
// - link_mode_one bits 4 to 7 enable comparator pairs 1 to 4.
// - Mode registers are host-only and never raise an interrupt themselves.
// - error_irq_enable bit n gates link error flag n; all off by default.
// - status_irq_enable bits 0,1 enable address and end-of-transmit interrupts; default 1.
// - status_irq_enable bits 2 to 6 enable five status interrupts; default 0.
// - status_irq_enable bit 7 passes received FCS bytes into receive FIFO.
// - Bits 1:0 pick receive threshold 1/2/4/8 or extended 1/16/24/30.
// - Bits 3:2 pick transmit threshold 1/2/4/8 or extended 1/6/10/14.
// - Bit 4 selects interframe fill: 0 mark idle, 1 flag idle.
// - Bit 5 selects two-byte match or single byte chosen by bit 7.
// - Bit 6 includes first-byte command/response bit in matching.
// - address_match_status bits 0-3 report matching pairs; upper bits zero.
// - Random registers seed the generator on write, return its value on read.
// - Write-only port fills transmit FIFO; read-only port drains receive FIFO.
// - Enabled pairs compare stored bytes with incoming address; disabled ignored.
// - address_match_status holds results for two outstanding packets.

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // Shift-register storage keeps the head in a flop for the drain side
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("byte_fifo: unsupported size");
  end

  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_reg   <= '0;
      o_out_valid <= 1'b0;
      o_in_ready  <= 1'b1;
    end else begin
      count_reg   <= count_next;
      o_out_valid <= (count_next != '0);
      o_in_ready  <= (count_next != DEPTH_C);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (pop) begin
          if (push && (CW'(i) == count_reg - CW'(1))) begin
            mem_reg[i] <= i_in_data;
          end else if (i < DEPTH - 1) begin
            mem_reg[i] <= mem_reg[i+1];
          end
        end else if (push && (CW'(i) == count_reg)) begin
          mem_reg[i] <= i_in_data;
        end
      end
    end
  end

  assign o_out_data = mem_reg[0];
endmodule

module dchannel_link_mode_registers #(
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = dchannel_link_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_arst_n,
  // Indirect register access
  input  wire logic [7:0]                        i_reg_addr,
  input  wire logic                              i_reg_wr,
  input  wire logic                              i_reg_rd,
  input  wire logic [7:0]                        i_reg_wdata,
  output logic [7:0]                             o_reg_rdata,
  output logic                                   o_reg_rdata_valid,
  // Device conditions
  input  wire logic                              i_extended_fifo,
  input  wire logic                              i_idle_mode,
  input  wire dchannel_link_pkg::irq_sources_type i_irq_sources,
  output logic                                   o_irq,
  // Address comparators
  input  wire dchannel_link_pkg::addr_pair_type  i_pair_values [dchannel_link_pkg::PAIR_COUNT],
  input  wire logic                              i_rx_addr_valid,
  input  wire logic [7:0]                        i_rx_addr_first,
  input  wire logic [7:0]                        i_rx_addr_second,
  output logic                                   o_addr_match,
  // Framing controls
  output logic                                   o_use_tx_address,
  output logic                                   o_flag_idle,
  output logic [4:0]                             o_rx_threshold,
  output logic [4:0]                             o_tx_threshold,
  // Transmit byte stream toward the framer
  output logic                                   o_tx_valid,
  output logic [FIFO_WIDTH-1:0]                  o_tx_data,
  input  wire logic                              i_tx_ready,
  output logic                                   o_tx_port_ready,
  // Receive byte stream from the framer
  input  wire logic                              i_rx_valid,
  input  wire logic [FIFO_WIDTH-1:0]             i_rx_data,
  input  wire logic                              i_rx_is_fcs,
  output logic                                   o_rx_ready
);

  initial begin
    if (FIFO_WIDTH != 8) $error("dchannel_link_mode_registers: ports are one byte wide");
    if (FIFO_DEPTH < 2) $error("dchannel_link_mode_registers: fifo too shallow");
  end

  logic [7:0]  link_mode_one_reg;
  logic [7:0]  error_irq_enable_reg;
  logic [7:0]  status_irq_enable_reg;
  logic [7:0]  threshold_and_framing_mode_reg;
  logic [15:0] random_reg;
  logic [3:0]  match_fifo_reg [dchannel_link_pkg::MATCH_DEPTH];
  logic [1:0]  match_count_reg;

  logic        wr_hit_lm1, wr_hit_err, wr_hit_stat, wr_hit_tfm, wr_hit_rlo;
  logic        wr_hit_rhi, wr_hit_tx, rd_hit_asr, rd_hit_rx;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  function automatic logic [4:0] threshold_bytes(input logic [1:0] code, input logic ext,
                                                 input logic is_rx);
    if (is_rx) begin
      return ext ? dchannel_link_pkg::RX_THRESH_EXT[code] : dchannel_link_pkg::RX_THRESH_NORMAL[code];
    end
    return ext ? dchannel_link_pkg::TX_THRESH_EXT[code] : dchannel_link_pkg::TX_THRESH_NORMAL[code];
  endfunction

  assign wr_hit_lm1  = i_reg_wr && hit(i_reg_addr, dchannel_link_pkg::ADDR_LINK_MODE_ONE);
  assign wr_hit_err  = i_reg_wr && hit(i_reg_addr, dchannel_link_pkg::ADDR_ERROR_IRQ_ENABLE);
  assign wr_hit_stat = i_reg_wr && hit(i_reg_addr, dchannel_link_pkg::ADDR_STATUS_IRQ_ENABLE);
  assign wr_hit_tfm  = i_reg_wr && hit(i_reg_addr, dchannel_link_pkg::ADDR_THRESHOLD_FRAMING);
  assign wr_hit_rlo  = i_reg_wr && hit(i_reg_addr, dchannel_link_pkg::ADDR_RANDOM_VALUE_LOW);
  assign wr_hit_rhi  = i_reg_wr && hit(i_reg_addr, dchannel_link_pkg::ADDR_RANDOM_VALUE_HIGH);
  assign wr_hit_tx   = i_reg_wr && hit(i_reg_addr, dchannel_link_pkg::ADDR_TRANSMIT_FIFO_PORT);
  assign rd_hit_asr  = i_reg_rd && hit(i_reg_addr, dchannel_link_pkg::ADDR_ADDRESS_MATCH_STAT);
  assign rd_hit_rx   = i_reg_rd && hit(i_reg_addr, dchannel_link_pkg::ADDR_RECEIVE_FIFO_PORT);

  // Mode registers: host writes only, no interrupt source of their own
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_mode_one_reg     <= dchannel_link_pkg::RST_LINK_MODE_ONE;
      error_irq_enable_reg  <= dchannel_link_pkg::RST_ERROR_IRQ_ENABLE;
      status_irq_enable_reg <= dchannel_link_pkg::RST_STATUS_IRQ_ENABLE;
    end else begin
      if (wr_hit_lm1) link_mode_one_reg <= i_reg_wdata;
      if (wr_hit_err) error_irq_enable_reg <= i_reg_wdata;
      if (wr_hit_stat) status_irq_enable_reg <= i_reg_wdata;
    end
  end

  // Threshold codes are taken only in idle so the framer never sees a mid-packet change
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      threshold_and_framing_mode_reg <= dchannel_link_pkg::RST_THRESHOLD_FRAMING;
    end else if (wr_hit_tfm) begin
      threshold_and_framing_mode_reg[7:4] <= i_reg_wdata[7:4];
      if (i_idle_mode) begin
        threshold_and_framing_mode_reg[3:0] <= i_reg_wdata[3:0];
      end
    end
  end

  // Random generator: free-running LFSR, bytes reseeded by writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      random_reg <= dchannel_link_pkg::RST_RANDOM_SEED;
    end else if (wr_hit_rlo) begin
      random_reg[7:0] <= i_reg_wdata;
    end else if (wr_hit_rhi) begin
      random_reg[15:8] <= i_reg_wdata;
    end else if (random_reg == '0) begin
      // All-zero is the lock-up state of an XOR LFSR
      random_reg <= dchannel_link_pkg::RST_RANDOM_SEED;
    end else begin
      random_reg <= {1'b0, random_reg[15:1]} ^
                    (random_reg[0] ? dchannel_link_pkg::RANDOM_TAPS : 16'h0000);
    end
  end

  // Address comparison per pair
  logic [3:0] pair_hit;
  logic [7:0] first_mask;

  always_comb begin
    first_mask = 8'hFF;
    if (!threshold_and_framing_mode_reg[dchannel_link_pkg::TFM_CR_COMPARE]) begin
      first_mask[dchannel_link_pkg::CR_BIT] = 1'b0;
    end
    for (int i = 0; i < dchannel_link_pkg::PAIR_COUNT; i++) begin
      logic first_ok;
      logic second_ok;
      first_ok  = ((i_rx_addr_first ^ i_pair_values[i].first_byte) & first_mask) == 8'h00;
      second_ok = i_rx_addr_second == i_pair_values[i].second_byte;
      if (!threshold_and_framing_mode_reg[dchannel_link_pkg::TFM_SINGLE_BYTE]) begin
        pair_hit[i] = first_ok && second_ok;
      end else if (threshold_and_framing_mode_reg[dchannel_link_pkg::TFM_SECOND_ONLY]) begin
        pair_hit[i] = second_ok;
      end else begin
        pair_hit[i] = first_ok;
      end
      pair_hit[i] = pair_hit[i] &&
                    link_mode_one_reg[dchannel_link_pkg::LM1_PAIR_EN_LSB + i];
    end
  end

  // Two-deep match result queue; a push in the pop cycle is kept
  logic match_push;
  logic match_pop;

  assign match_push = i_rx_addr_valid && (pair_hit != 4'h0);
  assign match_pop  = rd_hit_asr && (match_count_reg != 2'd0);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      match_count_reg <= 2'd0;
      for (int i = 0; i < dchannel_link_pkg::MATCH_DEPTH; i++) begin
        match_fifo_reg[i] <= 4'h0;
      end
    end else begin
      if (match_pop) begin
        match_fifo_reg[0] <= (match_push && match_count_reg == 2'd1) ? pair_hit
                                                                      : match_fifo_reg[1];
        match_fifo_reg[1] <= (match_push && match_count_reg == 2'd2) ? pair_hit : 4'h0;
        match_count_reg   <= match_push ? match_count_reg : match_count_reg - 2'd1;
      end else if (match_push && match_count_reg != 2'(dchannel_link_pkg::MATCH_DEPTH)) begin
        match_fifo_reg[match_count_reg[0]] <= pair_hit;
        match_count_reg <= match_count_reg + 2'd1;
      end
    end
  end

  // Transmit FIFO behind the write-only port
  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (wr_hit_tx),
    .i_in_data   (i_reg_wdata),
    .o_in_ready  (o_tx_port_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  (o_tx_data),
    .i_out_ready (i_tx_ready)
  );

  // Receive FIFO behind the read-only port; FCS bytes dropped unless enabled
  logic       rx_push_valid;
  logic       rx_out_valid;
  logic [7:0] rx_out_data;

  assign rx_push_valid = i_rx_valid &&
                         (!i_rx_is_fcs ||
                          status_irq_enable_reg[dchannel_link_pkg::SIE_FCS_TO_FIFO]);

  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (rx_push_valid),
    .i_in_data   (i_rx_data),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (rx_out_valid),
    .o_out_data  (rx_out_data),
    .i_out_ready (rd_hit_rx)
  );

  // Read data; unmapped and write-only addresses read as zero
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    unique case (i_reg_addr)
      dchannel_link_pkg::ADDR_LINK_MODE_ONE:      rdata_next = link_mode_one_reg;
      dchannel_link_pkg::ADDR_ERROR_IRQ_ENABLE:   rdata_next = error_irq_enable_reg;
      dchannel_link_pkg::ADDR_STATUS_IRQ_ENABLE:  rdata_next = status_irq_enable_reg;
      dchannel_link_pkg::ADDR_THRESHOLD_FRAMING:  rdata_next = threshold_and_framing_mode_reg;
      dchannel_link_pkg::ADDR_RANDOM_VALUE_LOW:   rdata_next = random_reg[7:0];
      dchannel_link_pkg::ADDR_RANDOM_VALUE_HIGH:  rdata_next = random_reg[15:8];
      dchannel_link_pkg::ADDR_ADDRESS_MATCH_STAT: rdata_next = {4'h0, match_fifo_reg[0]};
      dchannel_link_pkg::ADDR_RECEIVE_FIFO_PORT:  rdata_next = rx_out_valid ? rx_out_data : 8'h00;
      default:                                    rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata       <= 8'h00;
      o_reg_rdata_valid <= 1'b0;
    end else begin
      o_reg_rdata_valid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_next;
      end
    end
  end

  // Interrupt gating: only the status conditions themselves raise the line
  logic gated_any;

  always_comb begin
    gated_any = 1'b0;
    gated_any |= i_irq_sources.tx_threshold &&
                 link_mode_one_reg[dchannel_link_pkg::LM1_TX_THRESH_IRQ];
    gated_any |= i_irq_sources.rx_threshold &&
                 link_mode_one_reg[dchannel_link_pkg::LM1_RX_THRESH_IRQ];
    gated_any |= i_irq_sources.end_rx_packet &&
                 link_mode_one_reg[dchannel_link_pkg::LM1_END_RX_IRQ];
    gated_any |= |(i_irq_sources.link_error_flags & error_irq_enable_reg);
    gated_any |= i_irq_sources.valid_address &&
                 status_irq_enable_reg[dchannel_link_pkg::SIE_VALID_ADDR];
    gated_any |= i_irq_sources.end_tx_packet &&
                 status_irq_enable_reg[dchannel_link_pkg::SIE_END_TX_PKT];
    gated_any |= i_irq_sources.last_rx_byte &&
                 status_irq_enable_reg[dchannel_link_pkg::SIE_LAST_RX_BYTE];
    gated_any |= i_irq_sources.rx_byte_avail &&
                 status_irq_enable_reg[dchannel_link_pkg::SIE_RX_BYTE_AVAIL];
    gated_any |= i_irq_sources.last_byte_tx &&
                 status_irq_enable_reg[dchannel_link_pkg::SIE_LAST_BYTE_TX];
    gated_any |= i_irq_sources.tx_buf_avail &&
                 status_irq_enable_reg[dchannel_link_pkg::SIE_TX_BUF_AVAIL];
    gated_any |= i_irq_sources.rx_packet_lost &&
                 status_irq_enable_reg[dchannel_link_pkg::SIE_RX_PKT_LOST];
  end

  // Framing controls and status outputs, all registered
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq            <= 1'b0;
      o_addr_match     <= 1'b0;
      o_use_tx_address <= 1'b0;
      o_flag_idle      <= 1'b0;
      o_rx_threshold   <= dchannel_link_pkg::RX_THRESH_NORMAL[0];
      o_tx_threshold   <= dchannel_link_pkg::TX_THRESH_NORMAL[0];
    end else begin
      o_irq            <= gated_any;
      o_addr_match     <= i_rx_addr_valid && (pair_hit != 4'h0);
      o_use_tx_address <= link_mode_one_reg[dchannel_link_pkg::LM1_TX_ADDR_EN];
      o_flag_idle      <= threshold_and_framing_mode_reg[dchannel_link_pkg::TFM_FLAG_IDLE];
      o_rx_threshold   <= threshold_bytes(
                            threshold_and_framing_mode_reg[dchannel_link_pkg::TFM_RX_THRESH_LSB +: 2],
                            i_extended_fifo, 1'b1);
      o_tx_threshold   <= threshold_bytes(
                            threshold_and_framing_mode_reg[dchannel_link_pkg::TFM_TX_THRESH_LSB +: 2],
                            i_extended_fifo, 1'b0);
    end
  end

endmodule

// *** test/dchannel_link_checker.sv ***
module dchannel_link_checker (
  input wire logic                               i_clk,
  input wire logic                               i_arst_n,
  input wire logic [7:0]                         i_reg_addr,
  input wire logic                               i_reg_wr,
  input wire logic                               i_reg_rd,
  input wire logic [7:0]                         i_reg_wdata,
  input wire logic                               o_reg_rdata_valid,
  input wire logic                               i_idle_mode,
  input wire logic                               i_extended_fifo,
  input wire dchannel_link_pkg::irq_sources_type i_irq_sources,
  input wire logic                               o_irq,
  input wire logic                               i_rx_addr_valid,
  input wire logic                               o_addr_match,
  input wire logic                               o_use_tx_address,
  input wire logic                               o_flag_idle,
  input wire logic [4:0]                         o_rx_threshold,
  input wire logic                               o_tx_valid,
  input wire logic [7:0]                         o_tx_data,
  input wire logic                               i_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence wr_mode_one;
    i_reg_wr && i_reg_addr == 8'h86;
  endsequence
  sequence wr_framing;
    i_reg_wr && i_reg_addr == 8'h8F;
  endsequence
  read_answer_a: assert property (i_reg_rd |=> o_reg_rdata_valid)
    else $error("Read not answered");
  read_pulse_a: assert property (!i_reg_rd |=> !o_reg_rdata_valid)
    else $error("Read valid without read");
  tx_address_a: assert property (wr_mode_one |=> ##1 o_use_tx_address == $past(i_reg_wdata[2], 2))
    else $error("Transmit address select wrong");
  fill_select_a: assert property (wr_framing |=> ##1 o_flag_idle == $past(i_reg_wdata[4], 2))
    else $error("Interframe fill wrong");
  irq_quiet_a: assert property ((i_irq_sources == '0) [*2] |-> !o_irq)
    else $error("Interrupt without source");
  // Three cycles cover a write taken just before idle dropped
  thresh_hold_a: assert property ((!i_idle_mode && $stable(i_extended_fifo)) [*3] |-> $stable(o_rx_threshold))
    else $error("Threshold changed outside idle");
  match_pulse_a: assert property (!i_rx_addr_valid |=> !o_addr_match)
    else $error("Match without address");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("Transmit head dropped");
endmodule

bind dchannel_link_mode_registers dchannel_link_checker u_dchannel_link_checker (.*);

// *** test/framer_model.sv ***
module framer_model (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_hold,
  output logic      o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ready every other cycle, so the head byte must stand through stalls
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_ready <= 1'b0;
    else o_ready <= !i_hold && !o_ready;
  end
endmodule

// *** test/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_arst_n, i_reg_wr, i_reg_rd, i_extended_fifo, i_idle_mode, hold, i_tx_ready;
  logic i_rx_addr_valid, i_rx_valid, i_rx_is_fcs, o_reg_rdata_valid, o_irq, o_addr_match;
  logic o_use_tx_address, o_flag_idle, o_tx_valid, o_tx_port_ready, o_rx_ready;
  logic [7:0] i_reg_addr, i_reg_wdata, i_rx_addr_first, i_rx_addr_second, i_rx_data;
  logic [7:0] o_reg_rdata, o_tx_data, rd, v;
  logic [4:0] o_rx_threshold, o_tx_threshold;
  logic [7:0] q [$];
  logic [7:0] ra [6] = '{8'h86, 8'h87, 8'h8E, 8'h8F, 8'h91, 8'h80};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  int         num_errors, compares, n;
  int         eb [10] = '{0, 1, 0, 3, 1, 2, 3, 4, 5, 6};
  dchannel_link_pkg::irq_sources_type i_irq_sources;
  dchannel_link_pkg::addr_pair_type   i_pair_values [4];
  dchannel_link_mode_registers u_dchannel_link_mode_registers (.*);
  framer_model u_framer_model (.i_clk, .i_arst_n, .i_hold(hold), .o_ready(i_tx_ready));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  function automatic logic [7:0] thr(logic [1:0] c, logic x, logic t);
    case (c)
      2'h0: return 8'h01;
      2'h1: return x ? (t ? 8'h06 : 8'h10) : 8'h02;
      2'h2: return x ? (t ? 8'h0A : 8'h18) : 8'h04;
      default: return x ? (t ? 8'h0E : 8'h1E) : 8'h08;
    endcase
  endfunction
  task automatic check(string nm, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Strobes idle a cycle after each access so no signal changes twice at one edge
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    i_reg_addr = a; i_reg_wdata = d; i_reg_wr = 1'b1;
    @(negedge i_clk) i_reg_wr = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic rreg(logic [7:0] a, output logic [7:0] d);
    i_reg_addr = a; i_reg_rd = 1'b1;
    @(negedge i_clk) i_reg_rd = 1'b0;
    d = o_reg_rdata;
    @(negedge i_clk);
  endtask
  task automatic apulse(logic [7:0] f, logic [7:0] s, logic e);
    i_rx_addr_first = f; i_rx_addr_second = s; i_rx_addr_valid = 1'b1;
    @(negedge i_clk) i_rx_addr_valid = 1'b0;
    check("match", {7'h00, o_addr_match}, {7'h00, e});
  endtask
  initial begin
    void'($urandom(32'h5CDF));
    {i_arst_n, i_reg_wr, i_reg_rd, i_extended_fifo, i_rx_addr_valid, i_rx_valid} = '0;
    {i_reg_addr, i_reg_wdata, i_rx_addr_first, i_rx_addr_second, i_rx_data} = '0;
    {i_idle_mode, hold, i_rx_is_fcs, i_irq_sources} = {1'b1, 1'b1, 1'b0, 18'h00000};
    foreach (i_pair_values[j]) i_pair_values[j] = {2'(j), 6'($urandom), 8'($urandom)};
    repeat (16) @(negedge i_clk);
    i_arst_n = 1'b1;
    foreach (ra[k]) begin
      rreg(ra[k], rd);
      check("reset", rd, rv[k]);
    end
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      wreg(ra[k], v);
      rreg(ra[k], rd);
      check("rw", rd, v);
    end
    i_idle_mode = 1'b0;
    wreg(8'h8F, ~v);
    rreg(8'h8F, rd);
    check("idle_lock", rd, {~v[7:4], v[3:0]});
    check("fill", {7'h00, o_flag_idle}, {7'h00, ~v[4]});
    i_idle_mode = 1'b1;
    $display("register test done");
    for (int c = 0; c < 32; c++) begin
      i_extended_fifo = c[4];
      wreg(8'h8F, 8'(c[3:0]));
      check("rx_thr", {3'h0, o_rx_threshold}, thr(c[1:0], c[4], 1'b0));
      check("tx_thr", {3'h0, o_tx_threshold}, thr(c[3:2], c[4], 1'b1));
    end
    $display("threshold test done");
    wreg(8'h8E, 8'h00);
    wreg(8'h86, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wreg(8'h87, 8'h01 << k);
      i_irq_sources.link_error_flags = ~(8'h01 << k);
      repeat (2) @(negedge i_clk);
      check("irq_off", {7'h00, o_irq}, 8'h00);
      i_irq_sources.link_error_flags = 8'h01 << k;
      repeat (2) @(negedge i_clk);
      check("irq_on", {7'h00, o_irq}, 8'h01);
    end
    wreg(8'h87, 8'h00);
    for (int k = 0; k < 10; k++) begin
      i_irq_sources = 18'h20000 >> k;
      v = (k < 2 || k == 3) ? 8'h86 : 8'h8E;
      repeat (2) @(negedge i_clk);
      check("src_off", {7'h00, o_irq}, 8'h00);
      wreg(v, 8'h01 << eb[k]);
      check("src_on", {7'h00, o_irq}, 8'h01);
      wreg(v, 8'h00);
    end
    i_irq_sources = '0;
    $display("interrupt test done");
    wreg(8'h8F, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wreg(8'h86, 8'h10 << ((k + 1) % 4));
      apulse(i_pair_values[k].first_byte, i_pair_values[k].second_byte, 1'b0);
      wreg(8'h86, 8'h10 << k);
      apulse(i_pair_values[k].first_byte ^ 8'h02, i_pair_values[k].second_byte, 1'b1);
      rreg(8'h91, rd);
      check("asr", rd, 8'h01 << k);
    end
    wreg(8'h86, 8'h10);
    v = i_pair_values[0].first_byte;
    wreg(8'h8F, 8'h60);
    apulse(v ^ 8'h02, i_pair_values[0].second_byte, 1'b0);
    wreg(8'h8F, 8'hA0);
    apulse(~v, i_pair_values[0].second_byte, 1'b1);
    $display("address test done");
    for (int i = 0; i < 5; i++) begin
      check("tx_port", {7'h00, o_tx_port_ready}, {7'h00, 1'(i < 4)});
      v = 8'($urandom);
      if (i < 4) q.push_back(v);
      wreg(8'h92, v);
    end
    hold = 1'b0;
    n = 0;
    while (q.size() > 0) begin
      @(negedge i_clk);
      if (o_tx_valid && i_tx_ready) check("tx_data", o_tx_data, q.pop_front());
      n++;
      if (n > 60) begin
        num_errors++;
        test_done();
      end
    end
    for (int i = 0; i < 5; i++) begin
      v = 8'($urandom);
      if (i > 0) q.push_back(v);
      {i_rx_data, i_rx_is_fcs, i_rx_valid} = {v, 1'(i == 0), 1'b1};
      @(negedge i_clk) i_rx_valid = 1'b0;
      @(negedge i_clk);
    end
    check("rx_full", {7'h00, o_rx_ready}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rreg(8'h93, rd);
      check("rx_data", rd, (i < 4) ? q.pop_front() : 8'h00);
    end
    $display("fifo test done");
    test_done();
  end
endmodule
